// File: memory_interface_paging_config.sv
// memory interface configuration, refresh timing, sdram init and small aperture paging
//
// Contract
// [RQ1] When the low-latency bit is set the interface accepts client requests as late as possible.
// [RQ2] With pullback set, the display-enable indication is held on until the horizontal sync.
// [RQ3] The 3-bit pixel width field selects 1, 4, 8, 15, 16, 24 or 32 bpp, with 7 reserved.
// [RQ4] The 2-bit select picks sdram clock, dram enable, memory clock or system clock for the pin.
// [RQ5] Any select value other than 00 breaks the delay-locked-loop lock.
// [RQ6] The refresh rate field sets one refresh per 1024, 768, 512 or 256 memory clocks.
// [RQ7] The loop reset fires only on a 0 to 1 transition of its bit, not on the level.
// [RQ8] Two write page pointers exist, one per 32K aperture at segments A000 and A800.
// [RQ9] Each page pointer selects a 32K-aligned window, with no finer placement.
// [RQ10] Writes are mapped by the write pointer, held apart from the read pointer.
// [RQ11] Two read page pointers map host reads through each aperture.
// [RQ12] Apertures answer only in accelerator mode with the small-aperture enable set.
// [RQ13] On a PCI host bus the small apertures are not supported.
// [RQ14] The video address is the page pointer concatenated with the 15-bit offset.
// [RQ15] A 0 to 1 sdram reset bit runs precharge, eight refreshes, then a mode register set.
`timescale 1ns/100ps
module memory_interface_paging_config (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // system straps and mode
  input wire logic accel_mode_i,
  input wire logic small_aperture_enable_i,
  input wire logic bus_is_pci_i,
  // host aperture access
  input wire memif_pkg::ap_req_t ap_req_i,
  output logic ap_hit_o,
  output memif_pkg::vmem_req_t vmem_o,
  // display timing
  input wire logic display_enable_i,
  input wire logic hsync_i,
  output logic display_enable_indication_o,
  // output-enable pin sources
  input wire logic sdram_clk_i,
  input wire logic dram_oe_i,
  input wire logic mem_clk_test_i,
  input wire logic system_clock_i,
  output logic memory_output_enable_pin_o,
  // memory side controls
  output logic low_latency_o,
  output logic [5:0] aperture_bpp_o,
  output logic dll_reset_o,
  output logic dll_lock_break_o,
  output logic refresh_req_o,
  output memif_pkg::init_cmd_t init_cmd_o,
  output logic init_busy_o
);

  typedef enum logic [1:0] {INIT_IDLE, INIT_PRE, INIT_REF, INIT_MRS} init_state_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] wr_page;
    logic [31:0] rd_page;
    logic [31:0] rdata;
    logic dll_bit_q;
    logic sdram_bit_q;
    logic dll_pulse;
    logic [10:0] refresh_cnt;
    logic refresh_pulse;
    init_state_t init_state;
    logic [2:0] init_cnt;
    memif_pkg::init_cmd_t cmd;
    logic de_hold;
    logic oe_pin;
    memif_pkg::vmem_req_t vmem;
  } state_t;

  state_t r;
  state_t next_r;
  logic [1:0] rst_sync;
  logic rst_n;

  // decode pixel width code to bits per pixel, 0 for the reserved code
  function automatic logic [5:0] bpp_of(input logic [2:0] code);
    unique case (code)
      3'h0: bpp_of = 6'h01;
      3'h1: bpp_of = 6'h04;
      3'h2: bpp_of = 6'h08;
      3'h3: bpp_of = 6'h0F;
      3'h4: bpp_of = 6'h10;
      3'h5: bpp_of = 6'h18;
      3'h6: bpp_of = 6'h20;
      3'h7: bpp_of = 6'h00;
    endcase
  endfunction

  // refresh interval in cycles for a rate code
  function automatic logic [10:0] interval_of(input logic [1:0] code);
    unique case (code)
      2'h0: interval_of = memif_pkg::REFRESH_1024;
      2'h1: interval_of = memif_pkg::REFRESH_768;
      2'h2: interval_of = memif_pkg::REFRESH_512;
      2'h3: interval_of = memif_pkg::REFRESH_256;
    endcase
  endfunction

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [1:0] oe_sel;
  logic ap_open;
  logic [memif_pkg::PAGE_W-1:0] page;

  always_comb begin
    oe_sel = r.ctrl[memif_pkg::OE_SELECT_LSB +: 2];
    ap_open = accel_mode_i && small_aperture_enable_i && !bus_is_pci_i; // [RQ12] [RQ13]
    if (ap_req_i.write) begin
      page = ap_req_i.upper ? r.wr_page[memif_pkg::UPPER_PAGE_LSB +: memif_pkg::PAGE_W]
                            : r.wr_page[memif_pkg::LOWER_PAGE_LSB +: memif_pkg::PAGE_W]; // [RQ10]
    end else begin
      page = ap_req_i.upper ? r.rd_page[memif_pkg::UPPER_PAGE_LSB +: memif_pkg::PAGE_W]
                            : r.rd_page[memif_pkg::LOWER_PAGE_LSB +: memif_pkg::PAGE_W]; // [RQ11]
    end
    next_r = r;
    // register file
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        memif_pkg::MEM_CTRL_ADDR: next_r.ctrl = reg_wdata_i;
        memif_pkg::WR_PAGE_ADDR: next_r.wr_page = reg_wdata_i; // [RQ8]
        memif_pkg::RD_PAGE_ADDR: next_r.rd_page = reg_wdata_i; // [RQ11]
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        memif_pkg::MEM_CTRL_ADDR: next_r.rdata = r.ctrl;
        memif_pkg::WR_PAGE_ADDR: next_r.rdata = r.wr_page;
        memif_pkg::RD_PAGE_ADDR: next_r.rdata = r.rd_page;
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    // edge detection on control bits; the level alone never fires
    next_r.dll_bit_q = r.ctrl[memif_pkg::DLL_RESET_BIT];
    next_r.sdram_bit_q = r.ctrl[memif_pkg::SDRAM_RESET_BIT];
    next_r.dll_pulse = r.ctrl[memif_pkg::DLL_RESET_BIT] && !r.dll_bit_q; // [RQ7]
    // refresh interval counter; a new rate takes effect at the next wrap
    next_r.refresh_pulse = 1'b0;
    if (r.refresh_cnt == 11'h000) begin
      next_r.refresh_cnt = interval_of(r.ctrl[memif_pkg::REFRESH_RATE_LSB +: 2]) - 11'h001; // [RQ6]
      next_r.refresh_pulse = 1'b1;
    end else begin
      next_r.refresh_cnt = r.refresh_cnt - 11'h001;
    end
    // sdram initialisation, one command per cycle
    next_r.cmd = memif_pkg::CMD_NONE;
    unique case (r.init_state)
      INIT_IDLE: begin
        if (r.ctrl[memif_pkg::SDRAM_RESET_BIT] && !r.sdram_bit_q) begin
          next_r.init_state = INIT_PRE; // [RQ15]
        end
      end
      INIT_PRE: begin
        next_r.cmd = memif_pkg::CMD_PRECHARGE; // [RQ15]
        next_r.init_cnt = 3'h0;
        next_r.init_state = INIT_REF;
      end
      INIT_REF: begin
        next_r.cmd = memif_pkg::CMD_REFRESH; // [RQ15]
        next_r.init_cnt = r.init_cnt + 3'h1;
        if (r.init_cnt == memif_pkg::INIT_REFRESH_LAST) begin
          next_r.init_state = INIT_MRS;
        end
      end
      INIT_MRS: begin
        next_r.cmd = memif_pkg::CMD_MODE_SET; // [RQ15]
        next_r.init_state = INIT_IDLE;
      end
    endcase
    // display enable extension up to the next horizontal sync
    if (!r.ctrl[memif_pkg::PULLBACK_BIT] || hsync_i) begin
      next_r.de_hold = 1'b0;
    end else if (display_enable_i) begin
      next_r.de_hold = 1'b1; // [RQ2]
    end
    // output-enable pin source; test clocks only pass as sampled levels
    unique case (memif_pkg::oe_select_t'(oe_sel))
      memif_pkg::OE_SDRAM_CLK: next_r.oe_pin = sdram_clk_i; // [RQ4]
      memif_pkg::OE_DRAM: next_r.oe_pin = dram_oe_i;
      memif_pkg::OE_MEM_CLK: next_r.oe_pin = mem_clk_test_i;
      memif_pkg::OE_SYS_CLK: next_r.oe_pin = system_clock_i;
    endcase
    // aperture mapping on 32K pages
    next_r.vmem.valid = ap_req_i.req && ap_open;
    next_r.vmem.write = ap_req_i.write;
    next_r.vmem.addr = {page, ap_req_i.offset}; // [RQ9] [RQ14]
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.ctrl <= memif_pkg::MEM_CTRL_RESET;
      r.wr_page <= memif_pkg::PAGE_SEL_RESET;
      r.rd_page <= memif_pkg::PAGE_SEL_RESET;
      r.init_state <= INIT_IDLE;
      r.cmd <= memif_pkg::CMD_NONE;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata_o = r.rdata;
  assign ap_hit_o = ap_req_i.req && ap_open; // [RQ12]
  assign vmem_o = r.vmem;
  assign display_enable_indication_o = display_enable_i || r.de_hold; // [RQ2]
  assign memory_output_enable_pin_o = r.oe_pin;
  assign low_latency_o = r.ctrl[memif_pkg::LOW_LATENCY_BIT]; // [RQ1]
  assign aperture_bpp_o = bpp_of(r.ctrl[memif_pkg::PIX_WIDTH_LSB +: 3]); // [RQ3]
  assign dll_reset_o = r.dll_pulse;
  assign dll_lock_break_o = (oe_sel != 2'h0); // [RQ5]
  assign refresh_req_o = r.refresh_pulse;
  assign init_cmd_o = r.cmd;
  assign init_busy_o = (r.init_state != INIT_IDLE);

  property p_dll_edge;
    @(posedge ref_clk_i) disable iff (!rst_n)
    dll_reset_o |-> $past(r.ctrl[memif_pkg::DLL_RESET_BIT], 1) && !$past(r.dll_bit_q, 1);
  endproperty
  a_dll_edge: assert property (p_dll_edge) else $error("loop reset without rising edge"); // [RQ7]

  property p_dll_single;
    @(posedge ref_clk_i) disable iff (!rst_n)
    dll_reset_o |=> !dll_reset_o;
  endproperty
  a_dll_single: assert property (p_dll_single) else $error("loop reset held on level"); // [RQ7]

  property p_lock_break;
    @(posedge ref_clk_i) disable iff (!rst_n)
    reg_wr_i && reg_addr_i == memif_pkg::MEM_CTRL_ADDR
      |=> dll_lock_break_o == ($past(reg_wdata_i[memif_pkg::OE_SELECT_LSB +: 2]) != 2'h0);
  endproperty
  a_lock_break: assert property (p_lock_break) else $error("lock break mismatch"); // [RQ5]

  property p_init_seq;
    @(posedge ref_clk_i) disable iff (!rst_n)
    init_cmd_o == memif_pkg::CMD_PRECHARGE
      |=> (init_cmd_o == memif_pkg::CMD_REFRESH) [*8] ##1 init_cmd_o == memif_pkg::CMD_MODE_SET;
  endproperty
  a_init_seq: assert property (p_init_seq) else $error("bad sdram init sequence"); // [RQ15]

  property p_init_start;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (r.init_state == INIT_IDLE) && $rose(r.ctrl[memif_pkg::SDRAM_RESET_BIT])
      |=> ##1 init_cmd_o == memif_pkg::CMD_PRECHARGE;
  endproperty
  a_init_start: assert property (p_init_start) else $error("init not started"); // [RQ15]

  property p_refresh_512;
    @(posedge ref_clk_i) disable iff (!rst_n)
    refresh_req_o && r.ctrl[memif_pkg::REFRESH_RATE_LSB +: 2] == 2'h2
      && $stable(r.ctrl[memif_pkg::REFRESH_RATE_LSB +: 2])
      |-> r.refresh_cnt == 11'h1FF;
  endproperty
  a_refresh_512: assert property (p_refresh_512) else $error("refresh interval wrong"); // [RQ6]

  property p_ap_closed;
    @(posedge ref_clk_i) disable iff (!rst_n)
    (bus_is_pci_i || !accel_mode_i || !small_aperture_enable_i) |=> !vmem_o.valid;
  endproperty
  a_ap_closed: assert property (p_ap_closed) else $error("aperture answered while closed"); // [RQ12]

  property p_wr_map;
    @(posedge ref_clk_i) disable iff (!rst_n)
    ap_hit_o && ap_req_i.write && !ap_req_i.upper && !reg_wr_i
      |=> vmem_o.valid && vmem_o.write
        && vmem_o.addr == {r.wr_page[memif_pkg::PAGE_W-1:0], $past(ap_req_i.offset)};
  endproperty
  a_wr_map: assert property (p_wr_map) else $error("write page mapping wrong"); // [RQ10]

  property p_rd_map;
    @(posedge ref_clk_i) disable iff (!rst_n)
    ap_hit_o && !ap_req_i.write && ap_req_i.upper && !reg_wr_i
      |=> vmem_o.addr == {r.rd_page[memif_pkg::UPPER_PAGE_LSB +: memif_pkg::PAGE_W],
                          $past(ap_req_i.offset)};
  endproperty
  a_rd_map: assert property (p_rd_map) else $error("read page mapping wrong"); // [RQ11]

  property p_pullback;
    @(posedge ref_clk_i) disable iff (!rst_n)
    r.ctrl[memif_pkg::PULLBACK_BIT] && display_enable_i && !hsync_i
      && !reg_wr_i ##1 !hsync_i |-> display_enable_indication_o;
  endproperty
  a_pullback: assert property (p_pullback) else $error("display enable not extended"); // [RQ2]

endmodule

// File: memif_pkg.sv
// shared constants and types for the memory interface paging and configuration block
package memif_pkg;

  // register byte addresses
  localparam logic [7:0] MEM_CTRL_ADDR = 8'h2C;
  localparam logic [7:0] WR_PAGE_ADDR = 8'hB0;
  localparam logic [7:0] RD_PAGE_ADDR = 8'hB4;

  // memory_interface_control field positions
  localparam int REFRESH_RATE_LSB = 12;
  localparam int DLL_RESET_BIT = 14;
  localparam int SDRAM_RESET_BIT = 18;
  localparam int LOW_LATENCY_BIT = 20;
  localparam int PULLBACK_BIT = 21;
  localparam int PIX_WIDTH_LSB = 24;
  localparam int OE_SELECT_LSB = 27;

  // page select field positions
  localparam int LOWER_PAGE_LSB = 0;
  localparam int UPPER_PAGE_LSB = 16;
  localparam int PAGE_W = 8;
  localparam int OFFSET_W = 15;
  localparam int VMEM_ADDR_W = PAGE_W + OFFSET_W;

  // reset values
  localparam logic [31:0] MEM_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PAGE_SEL_RESET = 32'h0000_0000;

  // refresh intervals in memory clock cycles
  localparam logic [10:0] REFRESH_1024 = 11'h400;
  localparam logic [10:0] REFRESH_768 = 11'h300;
  localparam logic [10:0] REFRESH_512 = 11'h200;
  localparam logic [10:0] REFRESH_256 = 11'h100;

  // index of the last of the eight refresh cycles in the sdram initialisation sequence
  localparam logic [2:0] INIT_REFRESH_LAST = 3'h7;

  // output-enable pin sources
  typedef enum logic [1:0] {
    OE_SDRAM_CLK = 2'h0,
    OE_DRAM = 2'h1,
    OE_MEM_CLK = 2'h2,
    OE_SYS_CLK = 2'h3
  } oe_select_t;

  // sdram initialisation commands
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_PRECHARGE = 2'h1,
    CMD_REFRESH = 2'h2,
    CMD_MODE_SET = 2'h3
  } init_cmd_t;

  // host access through a small aperture
  typedef struct packed {
    logic req;
    logic write;
    logic upper;
    logic [OFFSET_W-1:0] offset;
  } ap_req_t;

  // mapped video memory access
  typedef struct packed {
    logic valid;
    logic write;
    logic [VMEM_ADDR_W-1:0] addr;
  } vmem_req_t;

endpackage

// File: video_memory_model.sv
// memory-side model: counts refresh pulses and init refresh commands
`timescale 1ns/100ps
module video_memory_model (
  // clock
  input wire logic ref_clk_i,
  // memory commands
  input wire logic refresh_i,
  input wire memif_pkg::init_cmd_t cmd_i,
  // observation
  output int n_refresh_o,
  output int n_init_ref_o
);
  initial begin
    n_refresh_o = 0;
    n_init_ref_o = 0;
  end
  // a refresh is one pulse, so each high sample is one refresh
  always @(posedge ref_clk_i) begin
    if (refresh_i === 1'h1)
      n_refresh_o <= n_refresh_o + 1;
    if (cmd_i === memif_pkg::CMD_REFRESH)
      n_init_ref_o <= n_init_ref_o + 1;
  end
endmodule

// File: memory_interface_paging_config_bench.sv
// self-checking bench for the memory interface paging and configuration block
`timescale 1ns/100ps
module memory_interface_paging_config_bench;
  localparam logic [7:0] CA = memif_pkg::MEM_CTRL_ADDR;
  localparam logic [7:0] WA = memif_pkg::WR_PAGE_ADDR;
  localparam logic [7:0] RA = memif_pkg::RD_PAGE_ADDR;
  logic ref_clk_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic accel_mode_i = 1'h1, small_aperture_enable_i = 1'h1, bus_is_pci_i = 1'h0;
  memif_pkg::ap_req_t ap_req_i = '0;
  memif_pkg::vmem_req_t vmem_o;
  memif_pkg::init_cmd_t init_cmd_o;
  logic display_enable_i = 1'h0, hsync_i = 1'h0, display_enable_indication_o;
  // one-hot source levels: sdram clock, dram enable, memory clock, system clock
  logic [3:0] src = 4'h0;
  logic [5:0] aperture_bpp_o;
  logic ap_hit_o, memory_output_enable_pin_o, low_latency_o, dll_reset_o;
  logic dll_lock_break_o, refresh_req_o, init_busy_o;
  int n_mismatch = 0, n_checks = 0, cyc = 0;

  memory_interface_paging_config DUT (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .accel_mode_i, .small_aperture_enable_i,
    .bus_is_pci_i, .ap_req_i, .ap_hit_o, .vmem_o, .display_enable_i, .hsync_i,
    .display_enable_indication_o, .sdram_clk_i(src[0]), .dram_oe_i(src[1]),
    .mem_clk_test_i(src[2]), .system_clock_i(src[3]), .memory_output_enable_pin_o,
    .low_latency_o, .aperture_bpp_o, .dll_reset_o, .dll_lock_break_o, .refresh_req_o,
    .init_cmd_o, .init_busy_o);
  video_memory_model mem (.ref_clk_i, .refresh_i(refresh_req_o), .cmd_i(init_cmd_o),
    .n_refresh_o(), .n_init_ref_o());

  always #20 ref_clk_i = ~ref_clk_i;
  // whole run needs about 8000 cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tick(1);
    reg_wr_i = 1'h1;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick(1);
    reg_wr_i = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    tick(1);
    reg_rd_i = 1'h1;
    reg_addr_i = a;
    tick(1);
    reg_rd_i = 1'h0;
    chk(reg_rdata_o, exp, "register read");
  endtask
  task automatic ap(input logic w, u, input logic [14:0] off, input logic h,
                    input logic [22:0] ea);
    tick(1);
    ap_req_i = {1'h1, w, u, off};
    #1;
    chk(ap_hit_o, h, "aperture hit");
    tick(1);
    ap_req_i = '0;
    chk(vmem_o.valid, h, "mapped valid");
    if (h)
      chk({vmem_o.write, vmem_o.addr}, {w, ea}, "mapped access");
  endtask

  task automatic t_regs;
    rd(CA, 32'h0);
    rd(WA, 32'h0);
    rd(RA, 32'h0);
    wr(WA, 32'h00A5_003C);
    wr(RA, 32'h005A_00C3);
    rd(WA, 32'h00A5_003C);
    rd(RA, 32'h005A_00C3);
    rd(8'h40, 32'h0);
  endtask
  task automatic t_aperture;
    ap(1'h1, 1'h0, 15'h7FFF, 1'h1, {8'h3C, 15'h7FFF});
    ap(1'h1, 1'h1, 15'h0001, 1'h1, {8'hA5, 15'h0001});
    ap(1'h0, 1'h0, 15'h1234, 1'h1, {8'hC3, 15'h1234});
    ap(1'h0, 1'h1, 15'h4000, 1'h1, {8'h5A, 15'h4000});
    for (int k = 0; k < 8; k++) begin
      {accel_mode_i, small_aperture_enable_i, bus_is_pci_i} = 3'(k);
      ap(1'h1, 1'h0, 15'h0010, k == 6, {8'h3C, 15'h0010});
    end
  endtask
  task automatic t_width;
    int bpp[8] = '{1, 4, 8, 15, 16, 24, 32, 0};
    for (int c = 0; c < 8; c++) begin
      wr(CA, 32'(c) << memif_pkg::PIX_WIDTH_LSB);
      tick(1);
      chk(aperture_bpp_o, bpp[c], "pixel width");
    end
  endtask
  task automatic t_oe;
    for (int s = 0; s < 4; s++) begin
      wr(CA, 32'(s) << memif_pkg::OE_SELECT_LSB);
      src = 4'h1 << s;
      tick(2);
      chk(memory_output_enable_pin_o, 1'h1, "oe pin high");
      chk(dll_lock_break_o, s != 0, "lock break");
      src = ~(4'h1 << s);
      tick(2);
      chk(memory_output_enable_pin_o, 1'h0, "oe pin low");
    end
    wr(CA, 32'h0);
  endtask
  task automatic t_dll;
    wr(CA, 32'h1 << memif_pkg::DLL_RESET_BIT);
    tick(1);
    chk(dll_reset_o, 1'h1, "loop reset pulse");
    tick(1);
    chk(dll_reset_o, 1'h0, "loop reset length");
    // same level written again must not fire
    wr(CA, 32'h1 << memif_pkg::DLL_RESET_BIT);
    for (int k = 0; k < 4; k++) begin
      tick(1);
      chk(dll_reset_o, 1'h0, "loop reset on level");
    end
    wr(CA, 32'h0);
  endtask
  task automatic t_init;
    wr(CA, 32'h1 << memif_pkg::SDRAM_RESET_BIT);
    // edge seen one cycle after the write, precharge issued the cycle after that
    tick(1);
    for (int k = 0; k < 11; k++) begin
      tick(1);
      chk(init_cmd_o, k == 0 ? 1 : k < 9 ? 2 : k == 9 ? 3 : 0, "init command");
      if (k == 4 || k == 10)
        chk(init_busy_o, k == 4, "init busy");
    end
    chk(mem.n_init_ref_o, 8, "init refresh count");
    wr(CA, 32'h0);
  endtask
  task automatic t_refresh;
    int per[4] = '{1024, 768, 512, 256};
    int n;
    int base;
    for (int c = 3; c >= 0; c--) begin
      wr(CA, 32'(c) << memif_pkg::REFRESH_RATE_LSB);
      base = mem.n_refresh_o;
      // skip two pulses: the first may carry an interval loaded from the old rate
      repeat (2) begin
        while (mem.n_refresh_o == base)
          tick(1);
        base = mem.n_refresh_o;
      end
      n = 0;
      while (mem.n_refresh_o == base && n < 2000) begin
        tick(1);
        n++;
      end
      chk(n, per[c], "refresh interval");
    end
  endtask
  task automatic t_display;
    wr(CA, 32'h1 << memif_pkg::LOW_LATENCY_BIT);
    tick(1);
    chk(low_latency_o, 1'h1, "low latency on");
    display_enable_i = 1'h1;
    tick(1);
    display_enable_i = 1'h0;
    #1;
    chk(display_enable_indication_o, 1'h0, "no extension");
    wr(CA, 32'h1 << memif_pkg::PULLBACK_BIT);
    display_enable_i = 1'h1;
    tick(1);
    display_enable_i = 1'h0;
    tick(3);
    chk(display_enable_indication_o, 1'h1, "extended enable");
    chk(low_latency_o, 1'h0, "low latency off");
    hsync_i = 1'h1;
    tick(1);
    hsync_i = 1'h0;
    chk(display_enable_indication_o, 1'h0, "cut at hsync");
  endtask

  initial begin
    tick(12);
    rst_n_i = 1'h1;
    tick(3);
    t_regs();
    t_aperture();
    t_width();
    t_oe();
    t_dll();
    t_init();
    t_refresh();
    t_display();
    report_and_stop();
  end
endmodule
